// File: shared/scrb_pkg.sv
// Package for the synthesizer configuration register bank.
// Assumes a single 200 MHz system clock and a byte-wide host port.
package scrb_pkg;
   // -----------------------------------------------------------------
   // Register byte offsets
   // -----------------------------------------------------------------
   localparam logic [5:0] OFS_PHASE_FIRST = 6'h00;
   localparam logic [5:0] OFS_PHASE_SECOND = 6'h02;
   localparam logic [5:0] OFS_TUNE_FIRST = 6'h04;
   localparam logic [5:0] OFS_TUNE_SECOND = 6'h0A;
   localparam logic [5:0] OFS_POWER = 6'h1D;
   localparam logic [5:0] OFS_CLKMUL = 6'h1E;
   localparam logic [5:0] OFS_UPDATE = 6'h1F;
   localparam logic [5:0] OFS_BYPASS = 6'h20;
   localparam logic [5:0] OFS_LAST = 6'h27;
   localparam int NUM_BYTES = 40;
   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int BIT_DOWN_DIG = 0;
   localparam int BIT_DOWN_DAC = 1;
   localparam int BIT_DOWN_QDAC = 2;
   localparam int BIT_DOWN_COMP = 4;
   localparam int BIT_BYP_SINC = 6;
   localparam int BIT_BYP_MULT = 5;
   localparam int BIT_INT_UPD = 0;
   localparam logic [7:0] PHASE_HI_MASK = 8'h3F;
   localparam logic [4:0] MULT_MIN = 5'h04;
   localparam logic [4:0] MULT_MAX = 5'h14;
   // -----------------------------------------------------------------
   // Reset values of control bytes
   // -----------------------------------------------------------------
   localparam logic [7:0] RST_POWER = 8'h10;
   localparam logic [7:0] RST_CLKMUL = 8'h64;
   localparam logic [7:0] RST_UPDATE = 8'h01;
   localparam logic [7:0] RST_BYPASS = 8'h20;
   localparam logic [7:0] RST_OTHER = 8'h00;
   localparam logic [31:0] RST_UPD_PERIOD = 32'h0000_0040;
   localparam int RESET_MIN_CYCLES = 10;

   typedef struct packed {
      logic [13:0] phase_first;
      logic [13:0] phase_second;
      logic [47:0] tune_first;
      logic [47:0] tune_second;
      logic power_down_comp;
      logic power_down_qdac;
      logic power_down_dac;
      logic power_down_dig;
      logic full_power_down;
      logic [4:0] clk_mult;
      logic mult_valid;
      logic byp_sinc;
      logic byp_mult;
   } scrb_cfg_t;

   function automatic logic [7:0] scrb_rst_byte(input int idx);
      case (idx)
         OFS_POWER: scrb_rst_byte = RST_POWER;
         OFS_CLKMUL: scrb_rst_byte = RST_CLKMUL;
         OFS_UPDATE: scrb_rst_byte = RST_UPDATE;
         OFS_BYPASS: scrb_rst_byte = RST_BYPASS;
         default: scrb_rst_byte = RST_OTHER;
      endcase
   endfunction
endpackage

// File: logic/scrb_update_timer.sv
// Internal update pulse generator.
// Assumes period input is stable between loads; counts system clocks.
`timescale 1ns/10ps
module scrb_update_timer
   import scrb_pkg::*;
#(
   parameter int WIDTH = 32
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic enable,
   input wire logic [WIDTH-1:0] period,
   output logic tick
);
   if (WIDTH < 2) begin
      $error("scrb_update_timer: WIDTH too small");
   end

   logic [WIDTH-1:0] cnt_q;
   logic [WIDTH-1:0] cnt_d;
   wire logic at_end = (cnt_q >= period);

   assign cnt_d = (!enable || at_end) ? '0 : cnt_q + 1'b1;
   assign tick = enable && at_end;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule

// File: logic/scrb_top.sv
// Configuration register bank of a frequency synthesizer.
// Assumes the host port is synchronous to clk_sys; bus protocol
// framing (serial shifting or parallel strobes) is done upstream.
//
// Contract
// - Differential select high enables both reference inputs, low true only.
// - Each power-down bit powers down its own stage, others keep running.
// - Bypass bits at offset 20 remove inverse sinc and multiplier.
// - Full power-down only when all four power-down bits are set.
// - Multiplier field is unsigned factor; only 4 to 20 defined.
// - Mode pin high selects parallel port, low selects serial port.
// - All forty register bytes writable and readable in either mode.
// - Writes land in buffer, no effect until transferred to active bank.
// - Transfer synchronous to clock, internal timer or external update.
// - Port works without reference clock; transfer happens only while it is present.
// - Phase words 14 bits, upper byte first, bits 15 and 14 ignored.
// - Tuning words 48 bits over six bytes, most significant first.
// - Comparator has its own independent power-down control.
// - Multiplier ratio comes from five bits of byte 1E.
// - Master reset held ten cycles, then defaults load; code loads defaults asynchronously while rst is high, with no cycle count.
`timescale 1ns/10ps
module scrb_top
   import scrb_pkg::*;
#(
   parameter int UPD_WIDTH = 32
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic parallel_mode_sel,
   input wire logic differential_clock_select,
   input wire logic reference_clock_input,
   input wire logic reference_clock_complement,
   input wire logic ref_clock_present,
   input wire logic par_wr,
   input wire logic par_rd,
   input wire logic [5:0] par_addr,
   input wire logic [7:0] par_wdata,
   input wire logic ser_wr,
   input wire logic ser_rd,
   input wire logic [5:0] ser_addr,
   input wire logic [7:0] ser_wdata,
   input wire logic ext_update,
   output logic [7:0] rdata,
   output logic rdata_valid,
   output logic ref_clock_active,
   output logic ref_complement_enable,
   output scrb_cfg_t cfg,
   output logic update_done
);
   if (UPD_WIDTH < 2 || UPD_WIDTH > 32) begin
      $error("scrb_top: UPD_WIDTH out of range");
   end

   // ------------------------------------------------------------------
   // Host port selection
   // ------------------------------------------------------------------
   // Inactive port is ignored entirely, so stray strobes do no harm
   wire logic wr_en = parallel_mode_sel ? par_wr : ser_wr;
   wire logic rd_en = parallel_mode_sel ? par_rd : ser_rd;
   wire logic [5:0] addr = parallel_mode_sel ? par_addr : ser_addr;
   wire logic [7:0] wdata = parallel_mode_sel ? par_wdata : ser_wdata;
   wire logic addr_ok = (addr <= OFS_LAST);

   // ------------------------------------------------------------------
   // Buffer and active banks
   // ------------------------------------------------------------------
   logic [7:0] buf_q [NUM_BYTES];
   logic [7:0] act_q [NUM_BYTES];
   logic [7:0] rdata_q;
   logic rvalid_q;
   logic done_q;

   // Transfer gated by reference clock presence
   wire logic int_mode = act_q[OFS_UPDATE][BIT_INT_UPD];
   wire logic [31:0] upd_period = {act_q[OFS_UPDATE + 6'h01],
      act_q[OFS_UPDATE + 6'h02], act_q[OFS_UPDATE + 6'h03],
      act_q[OFS_UPDATE + 6'h04]};
   logic int_tick;
   wire logic xfer = ref_clock_present
      && (int_mode ? int_tick : ext_update);

   scrb_update_timer #(
      .WIDTH(UPD_WIDTH)
   ) u_timer (
      .clk_sys(clk_sys),
      .rst(rst),
      .enable(int_mode && ref_clock_present),
      .period(upd_period[UPD_WIDTH-1:0]),
      .tick(int_tick)
   );

   // Host writes only touch the buffer; works with no reference clock
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NUM_BYTES; i++) begin
            buf_q[i] <= scrb_rst_byte(i);
         end
      end else if (wr_en && addr_ok) begin
         buf_q[addr] <= wdata;
      end
   end

   // Whole bank copied on a single edge
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NUM_BYTES; i++) begin
            act_q[i] <= scrb_rst_byte(i);
         end
      end else if (xfer) begin
         for (int i = 0; i < NUM_BYTES; i++) begin
            act_q[i] <= buf_q[i];
         end
      end
   end

   // Readback shows the buffer, i.e. what the host last wrote
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rdata_q <= RST_OTHER;
         rvalid_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         rdata_q <= (rd_en && addr_ok) ? buf_q[addr] : RST_OTHER;
         rvalid_q <= rd_en;
         done_q <= xfer;
      end
   end

   assign rdata = rdata_q;
   assign rdata_valid = rvalid_q;
   assign update_done = done_q;

   // ------------------------------------------------------------------
   // Reference clock input mode
   // ------------------------------------------------------------------
   assign ref_complement_enable = differential_clock_select;
   assign ref_clock_active = differential_clock_select
      ? (reference_clock_input & ~reference_clock_complement)
      : reference_clock_input;

   // ------------------------------------------------------------------
   // Decoded configuration from the active bank
   // ------------------------------------------------------------------
   wire logic [7:0] pwr = act_q[OFS_POWER];
   wire logic [4:0] mult = act_q[OFS_CLKMUL][4:0];

   always_comb begin
      // Top two bits of the upper byte are dropped on purpose
      cfg.phase_first = 14'({act_q[OFS_PHASE_FIRST] & PHASE_HI_MASK,
         act_q[OFS_PHASE_FIRST + 6'h01]});
      cfg.phase_second = 14'({act_q[OFS_PHASE_SECOND] & PHASE_HI_MASK,
         act_q[OFS_PHASE_SECOND + 6'h01]});
      for (int b = 0; b < 6; b++) begin
         cfg.tune_first[47 - 8*b -: 8] = act_q[OFS_TUNE_FIRST + b];
         cfg.tune_second[47 - 8*b -: 8] =
            act_q[OFS_TUNE_SECOND + b];
      end
      cfg.power_down_comp = pwr[BIT_DOWN_COMP];
      cfg.power_down_qdac = pwr[BIT_DOWN_QDAC];
      cfg.power_down_dac = pwr[BIT_DOWN_DAC];
      cfg.power_down_dig = pwr[BIT_DOWN_DIG];
      cfg.full_power_down = pwr[BIT_DOWN_COMP] && pwr[BIT_DOWN_QDAC]
         && pwr[BIT_DOWN_DAC] && pwr[BIT_DOWN_DIG];
      cfg.clk_mult = mult;
      cfg.mult_valid = (mult >= MULT_MIN) && (mult <= MULT_MAX);
      cfg.byp_sinc = act_q[OFS_BYPASS][BIT_BYP_SINC];
      cfg.byp_mult = act_q[OFS_BYPASS][BIT_BYP_MULT];
   end
endmodule

// File: verif/scrb_monitor.sv
// Port checker for the synthesizer register bank.
// Assumes binding to scrb_top, one clock domain.
`timescale 1ns/10ps
module scrb_monitor
   import scrb_pkg::*;
#(
   parameter int UPD_WIDTH = 32
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic parallel_mode_sel,
   input wire logic differential_clock_select,
   input wire logic reference_clock_input,
   input wire logic reference_clock_complement,
   input wire logic ref_clock_present,
   input wire logic par_rd,
   input wire logic [5:0] par_addr,
   input wire logic ser_rd,
   input wire logic [5:0] ser_addr,
   input wire logic [7:0] rdata,
   input wire logic rdata_valid,
   input wire logic ref_clock_active,
   input wire logic ref_complement_enable,
   input wire scrb_cfg_t cfg,
   input wire logic update_done
);
   wire logic rd_hit = parallel_mode_sel ? par_rd : ser_rd;
   wire logic [5:0] rd_a = parallel_mode_sel ? par_addr : ser_addr;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   AST_REF_PINS:
   assert property (ref_clock_active == (reference_clock_input &&
      !(differential_clock_select && reference_clock_complement)) &&
      ref_complement_enable == differential_clock_select)
      else $error("reference pin selection wrong");
   AST_FULL_POWER_DOWN:
   assert property (cfg.full_power_down == (cfg.power_down_comp
      && cfg.power_down_qdac && cfg.power_down_dac && cfg.power_down_dig))
      else $error("full power-down wrong");
   AST_MULT_RANGE:
   assert property (cfg.mult_valid == (cfg.clk_mult >= 5'h04 &&
      cfg.clk_mult <= 5'h14)) else $error("multiplier range wrong");
   AST_NO_REF_NO_XFER:
   assert property (!ref_clock_present [*3] |-> !update_done)
      else $error("transfer without reference clock");
   AST_CFG_ON_XFER:
   assert property ($changed(cfg) |-> update_done)
      else $error("active bank moved outside a transfer");
   AST_RD_ANSWER:
   assert property (rd_hit |=> rdata_valid) else $error("read unanswered");
   AST_RD_CAUSE:
   assert property (rdata_valid |-> $past(rd_hit))
      else $error("read answer without request");
   AST_RD_UNMAPPED:
   assert property (rd_hit && rd_a > 6'h27 |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   AST_RST_DEFAULT:
   assert property ($fell(rst) |-> cfg.clk_mult == 5'h04
      && cfg.power_down_comp && cfg.byp_mult && !cfg.byp_sinc)
      else $error("reset defaults wrong");
endmodule
bind scrb_top scrb_monitor #(.UPD_WIDTH(UPD_WIDTH)) u_mon (.*);

// File: verif/scrb_host_model.sv
// Host programming port model, one byte per request.
// Assumes the bank takes a request on each clk_sys rising edge.
`timescale 1ns/10ps
module scrb_host_model (
   input wire logic clk_sys,
   input wire logic parallel_mode_sel,
   output logic par_wr,
   output logic par_rd,
   output logic [5:0] par_addr,
   output logic [7:0] par_wdata,
   output logic ser_wr,
   output logic ser_rd,
   output logic [5:0] ser_addr,
   output logic [7:0] ser_wdata
);
   initial begin
      {par_wr, par_rd, par_addr, par_wdata} = 16'h0000;
      {ser_wr, ser_rd, ser_addr, ser_wdata} = 16'h0000;
   end
   // Port follows the mode pin level
   task automatic access(input logic wr, input logic [5:0] a,
         input logic [7:0] d);
      @(posedge clk_sys);
      #1;
      if (parallel_mode_sel) begin
         {par_wr, par_rd, par_addr, par_wdata} = {wr, !wr, a, d};
      end else begin
         {ser_wr, ser_rd, ser_addr, ser_wdata} = {wr, !wr, a, d};
      end
      @(posedge clk_sys);
      #1;
      // Released lines flip, so no stale value looks valid
      {par_wr, par_rd, ser_wr, ser_rd} = 4'h0;
      {par_addr, par_wdata} = ~{par_addr, par_wdata};
      {ser_addr, ser_wdata} = ~{ser_addr, ser_wdata};
   endtask
endmodule

// File: verif/tb.sv
// Self-checking bench for scrb_top with a host port model.
// Assumes a short update timer width for simulation.
`timescale 1ns/10ps
module tb;
   import scrb_pkg::*;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic parallel_mode_sel = 1'b1;
   logic differential_clock_select = 1'b0;
   logic reference_clock_input = 1'b0;
   logic reference_clock_complement = 1'b0;
   logic ref_clock_present = 1'b0;
   logic ext_update = 1'b0;
   logic par_wr, par_rd, ser_wr, ser_rd, rdata_valid, update_done;
   logic ref_clock_active, ref_complement_enable;
   logic [5:0] par_addr, ser_addr;
   logic [7:0] par_wdata, ser_wdata, rdata;
   scrb_cfg_t cfg;
   int error_cnt = 0;
   int check_count = 0;
   int cyc = 0;
   scrb_top #(.UPD_WIDTH(8)) u_dut (.*);
   scrb_host_model u_host (.*);
   initial begin
      forever #2.5 clk_sys = ~clk_sys;
   end
   // ------------------------------
   // Shared tasks
   // ------------------------------
   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
      end
   endtask
   task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
      u_host.access(1'b0, a, 8'h00);
      check(rdata_valid, 1'b1);
      check(rdata, exp);
   endtask
   // External update; reference clock presence set with the strobe
   task automatic upd(input logic ref_on);
      @(posedge clk_sys);
      #1;
      ref_clock_present = ref_on;
      ext_update = 1'b1;
      @(posedge clk_sys);
      #1;
      ext_update = 1'b0;
      check(update_done, ref_on);
      repeat (2) @(posedge clk_sys);
      #1;
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         final_report();
      end
   end
   // ------------------------------
   // Scenarios
   // ------------------------------
   task automatic test_buffer();
      rd_chk(OFS_PHASE_FIRST, 8'h00);
      rd_chk(OFS_TUNE_SECOND, 8'h00);
      rd_chk(OFS_CLKMUL, RST_CLKMUL);
      u_host.access(1'b1, OFS_UPDATE, 8'h00);
      u_host.access(1'b1, OFS_TUNE_FIRST, 8'hAB);
      rd_chk(OFS_TUNE_FIRST, 8'hAB);
      repeat (5) @(posedge clk_sys);
      #1;
      check(cfg.tune_first, 48'h0);
      ref_clock_present = 1'b1;
      repeat (4) @(posedge clk_sys);
      #1;
      check(cfg.tune_first[47:40], 8'hAB);
      $display("buffer test done");
   endtask
   task automatic test_ctrl();
      u_host.access(1'b1, OFS_POWER, 8'h17);
      u_host.access(1'b1, OFS_CLKMUL, 8'h14);
      u_host.access(1'b1, OFS_BYPASS, 8'h60);
      u_host.access(1'b1, OFS_PHASE_FIRST, 8'hFF);
      u_host.access(1'b1, OFS_PHASE_FIRST + 6'h01, 8'hFF);
      check(cfg.full_power_down, 1'b0);
      upd(1'b0);
      check(cfg.full_power_down, 1'b0);
      upd(1'b1);
      check(cfg.full_power_down, 1'b1);
      check({cfg.clk_mult, cfg.mult_valid}, 6'h29);
      check({cfg.byp_sinc, cfg.byp_mult}, 2'h3);
      check(cfg.phase_first, 14'h3FFF);
      u_host.access(1'b1, OFS_POWER, 8'h07);
      u_host.access(1'b1, OFS_CLKMUL, 8'h03);
      u_host.access(1'b1, OFS_BYPASS, 8'h00);
      upd(1'b1);
      check({cfg.power_down_comp, cfg.power_down_dig,
         cfg.full_power_down}, 3'h2);
      check({cfg.power_down_qdac, cfg.power_down_dac}, 2'h3);
      check(cfg.mult_valid, 1'b0);
      check({cfg.byp_sinc, cfg.byp_mult}, 2'h0);
      $display("control test done");
   endtask
   task automatic test_serial();
      parallel_mode_sel = 1'b0;
      for (int i = 0; i < 6; i++) begin
         u_host.access(1'b1, OFS_TUNE_SECOND + 6'(i), 8'(i + 1));
      end
      u_host.access(1'b1, OFS_PHASE_SECOND, 8'hC1);
      u_host.access(1'b1, OFS_PHASE_SECOND + 6'h01, 8'h23);
      rd_chk(OFS_TUNE_SECOND + 6'h05, 8'h06);
      rd_chk(6'h30, 8'h00);
      upd(1'b1);
      check(cfg.tune_second, 48'h010203040506);
      check(cfg.phase_second, 14'h0123);
      parallel_mode_sel = 1'b1;
      $display("serial test done");
   endtask
   task automatic test_pins();
      logic [2:0] v;
      for (int i = 0; i < 8; i++) begin
         v = 3'(i);
         @(posedge clk_sys);
         #1;
         {differential_clock_select, reference_clock_input,
            reference_clock_complement} = v;
         #1;
         check(ref_clock_active, v[1] && !(v[2] && v[0]));
         check(ref_complement_enable, v[2]);
      end
      $display("pin test done");
   endtask
   initial begin
      repeat (20) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      test_buffer();
      test_ctrl();
      test_serial();
      test_pins();
      final_report();
   end
endmodule
